// ---- rtl/rsv_reset_seq.sv ----
// Reset sequencer with voltage monitor control registers
`timescale 1ns/1ns
`include "rsv_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE1 - Hold reset while each source lasts
// RULE2 - Main oscillator off in power or pin reset
// RULE3 - Count slow ticks per source before release
// RULE4 - Release synchronised to processor clock
// RULE5 - Precise power-on spares the bandgap trim; o_trim_rst still pulses for one cycle when the last source was another
// RULE6 - Status bits follow reset type
// RULE7 - Bandgap stays powered always
// RULE8 - Boot takes 2.2 ms to first fetch
// RULE9 - Slow oscillator stops only on coarse power-on
// RULE10 - Boot reset keeps main oscillator off
// RULE11 - Main oscillator on one tick before release
// RULE12 - Power, pin and watchdog resets clear voltage monitor control; boot reset leaves it unchanged
// RULE13 - Power-on level 11b is reserved
// RULE14 - Throttle enable and detect reset speed
// RULE15 - Trip select sets comparator level
// RULE16 - Status bit shows live comparator
// RULE17 - Low voltage raises system interrupt
// RULE18 - Power-on holds system until supplies good
// RULE19 - Software writes zero to reserved bits
// RULE20 - Watchdog status cleared only by zero
// RULE21 - Clearing power-on status enables watchdog
// RULE22 - Ten-bit or wider tick counter per source
module rsv_reset_seq #(
  parameter int BOOT_CYCLES = `RSV_BOOT_CYCLES
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // Reset sources
  input  wire logic       i_coarse_por,
  input  wire logic       i_precise_por,
  input  wire logic       i_ext_reset_pin,
  input  wire logic       i_wdt_expire,
  input  wire logic       i_boot_reset_req,
  // Comparator
  input  wire logic       i_lvd_cmp,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Resets and power
  output logic            o_cpu_rst,
  output logic            o_reg_rst,
  output logic            o_trim_rst,
  output logic            o_main_osc_en,
  output logic            o_slow_osc_en,
  output logic            o_bandgap_en,
  // Boot
  output logic            o_code_start,
  output logic     [15:0] o_boot_vector,
  // Monitor settings and status
  output logic      [1:0] o_por_level,
  output logic      [2:0] o_lvd_trip,
  output logic            o_throttle,
  output logic            o_lvd_irq,
  output logic            o_wdt_enable,
  output logic            o_mem_init_disable
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  //////////////////////////////////////////////////////////////////////////////

  logic [3:0] sync1_q;  // First stage, read only by second
  logic [3:0] sync2_q;  // Second stage, safe to use
  logic       coarse_s; // Coarse power-on level
  logic       precise_s; // Precise power-on level
  logic       ext_s;    // External pin level
  logic       lvd_s;    // Comparator level

  // Two flops on every asynchronous level
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= {i_lvd_cmp, i_ext_reset_pin, i_precise_por, i_coarse_por};
      sync2_q <= sync1_q;
    end
  end

  assign coarse_s  = sync2_q[0];
  assign precise_s = sync2_q[1];
  assign ext_s     = sync2_q[2];
  assign lvd_s     = sync2_q[3];

  //////////////////////////////////////////////////////////////////////////////
  // Slow tick divider
  //////////////////////////////////////////////////////////////////////////////

  logic [`RSV_DIV_W-1:0] div_q;    // Divider count
  logic                  tick;     // One-cycle slow tick
  logic                  tick_end; // Divider at terminal count

  assign tick_end = (div_q == `RSV_DIV_W'(`RSV_SLOW_DIV - 1));
  assign tick     = tick_end && !coarse_s;

  // Slow clock stands still under coarse power-on
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= '0;
    end else if (coarse_s || tick_end) begin
      div_q <= '0; // [RULE9]
    end else begin
      div_q <= div_q + `RSV_DIV_W'(1);
    end
  end

  assign o_slow_osc_en = !coarse_s; // [RULE9]

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state machine
  //////////////////////////////////////////////////////////////////////////////

  rsv_pkg::rsv_state_e   state_q;  // Current state
  rsv_pkg::rsv_state_e   state_d;  // Next state
  rsv_pkg::rsv_src_e     src_q;    // Last source seen
  rsv_pkg::rsv_src_e     src_d;    // Next source
  logic [`RSV_CNT_W-1:0] cnt_q;    // Hold-off tick counter
  logic [`RSV_CNT_W-1:0] cnt_d;    // Next counter value
  logic                  lvl_any;  // Any power or pin source active
  logic                  wdt_en;   // Watchdog armed
  logic                  por_q;    // Power-on status bit
  logic                  watchdog_status_bit_q;   // Watchdog status bit
  logic                  memdis_q; // Memory init disable bit

  assign lvl_any = coarse_s || precise_s || ext_s; // [RULE18]
  assign wdt_en  = !por_q; // [RULE21]

  // Hold-off count chosen by the source that ended
  function automatic logic [`RSV_CNT_W-1:0] hold_ticks(
    input rsv_pkg::rsv_src_e src
  );
    unique case (src)
      rsv_pkg::RSV_SRC_COARSE:  hold_ticks = `RSV_TICKS_COARSE;
      rsv_pkg::RSV_SRC_PRECISE: hold_ticks = `RSV_TICKS_PRECISE;
      rsv_pkg::RSV_SRC_EXT:     hold_ticks = `RSV_TICKS_EXT;
      rsv_pkg::RSV_SRC_WDT:     hold_ticks = `RSV_TICKS_WDT;
      default:                  hold_ticks = `RSV_TICKS_BOOT_ON;
    endcase
  endfunction

  // Source priority while levels are active
  function automatic rsv_pkg::rsv_src_e pick_src(
    input logic              c,
    input logic              p,
    input rsv_pkg::rsv_src_e cur,
    input logic              keep
  );
    if (c || (keep && cur == rsv_pkg::RSV_SRC_COARSE)) begin
      pick_src = rsv_pkg::RSV_SRC_COARSE;
    end else if (p || (keep && cur == rsv_pkg::RSV_SRC_PRECISE)) begin
      pick_src = rsv_pkg::RSV_SRC_PRECISE;
    end else begin
      pick_src = rsv_pkg::RSV_SRC_EXT;
    end
  endfunction

  // Next-state logic
  always_comb begin
    state_d = state_q;
    src_d   = src_q;
    cnt_d   = cnt_q;
    if (lvl_any) begin
      // Power or pin level wins from any state
      state_d = rsv_pkg::RSV_ST_HOLD; // [RULE1]
      src_d   = pick_src(coarse_s, precise_s, src_q,
                         state_q == rsv_pkg::RSV_ST_HOLD);
    end else begin
      unique case (state_q)
        rsv_pkg::RSV_ST_RUN: begin
          if (i_wdt_expire && wdt_en) begin
            state_d = rsv_pkg::RSV_ST_WDT;
            src_d   = rsv_pkg::RSV_SRC_WDT;
          end else if (i_boot_reset_req) begin
            state_d = rsv_pkg::RSV_ST_BOOT;
            src_d   = rsv_pkg::RSV_SRC_BOOT;
          end
        end
        rsv_pkg::RSV_ST_HOLD, rsv_pkg::RSV_ST_WDT: begin
          // Leave on a tick so the count runs whole ticks
          if (tick) begin
            state_d = rsv_pkg::RSV_ST_WAIT; // [RULE1]
            cnt_d   = hold_ticks(src_q); // [RULE3] [RULE22]
          end
        end
        rsv_pkg::RSV_ST_BOOT: begin
          // One tick of boot reset
          if (tick) begin
            state_d = rsv_pkg::RSV_ST_BOOT_LP;
            cnt_d   = `RSV_TICKS_BOOT_LP; // [RULE10]
          end
        end
        rsv_pkg::RSV_ST_BOOT_LP: begin
          // Low power hold-off after boot reset
          if (tick) begin
            if (cnt_q == `RSV_CNT_ONE) begin
              state_d = rsv_pkg::RSV_ST_WAIT;
              cnt_d   = hold_ticks(src_q);
            end else begin
              cnt_d = cnt_q - `RSV_CNT_ONE; // [RULE10]
            end
          end
        end
        rsv_pkg::RSV_ST_WAIT: begin
          // Main oscillator runs; count ticks to release
          if (tick) begin
            if (cnt_q == `RSV_CNT_ONE) begin
              state_d = rsv_pkg::RSV_ST_RUN; // [RULE3] [RULE11]
            end else begin
              cnt_d = cnt_q - `RSV_CNT_ONE; // [RULE3]
            end
          end
        end
        default: begin
          state_d = rsv_pkg::RSV_ST_HOLD;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= rsv_pkg::RSV_ST_HOLD;
      src_q   <= rsv_pkg::RSV_SRC_COARSE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      src_q   <= src_d;
      cnt_q   <= cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power and reset outputs
  //////////////////////////////////////////////////////////////////////////////

  logic osc_off;  // Main oscillator held off
  logic rst_raw;  // Processor reset before sync
  logic reg_rst;  // Register reset from a source
  logic [1:0] cpu_pipe_q; // Release synchroniser

  assign osc_off = lvl_any
                || (state_q == rsv_pkg::RSV_ST_HOLD)     // [RULE2]
                || (state_q == rsv_pkg::RSV_ST_BOOT)
                || (state_q == rsv_pkg::RSV_ST_BOOT_LP); // [RULE10]
  assign o_main_osc_en = !osc_off; // [RULE2] [RULE11]
  assign rst_raw = (state_q != rsv_pkg::RSV_ST_RUN) || lvl_any;
  assign reg_rst = lvl_any
                || (state_q == rsv_pkg::RSV_ST_HOLD)
                || (state_q == rsv_pkg::RSV_ST_WDT); // [RULE5]
  assign o_reg_rst  = reg_rst;
  assign o_trim_rst = reg_rst && (src_q != rsv_pkg::RSV_SRC_PRECISE); // [RULE5]
  assign o_bandgap_en = 1'b1; // [RULE7]

  // Assert on the next clock edge, release after two clock edges
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cpu_pipe_q <= 2'h3;
    end else if (rst_raw) begin
      cpu_pipe_q <= 2'h3;
    end else begin
      cpu_pipe_q <= {cpu_pipe_q[0], 1'b0}; // [RULE4]
    end
  end

  assign o_cpu_rst = cpu_pipe_q[1]; // [RULE4]

  //////////////////////////////////////////////////////////////////////////////
  // Boot timer
  //////////////////////////////////////////////////////////////////////////////

  logic [`RSV_BOOT_W-1:0] boot_q; // Cycles since release
  logic                   start_q; // Code may run from vector

  // Count boot time after processor release
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_q  <= '0;
      start_q <= 1'b0;
    end else if (o_cpu_rst) begin
      boot_q  <= '0;
      start_q <= 1'b0;
    end else if (boot_q == `RSV_BOOT_W'(BOOT_CYCLES - 1)) begin
      start_q <= 1'b1; // [RULE8]
    end else begin
      boot_q <= boot_q + `RSV_BOOT_W'(1);
    end
  end

  assign o_code_start  = start_q;
  assign o_boot_vector = `RSV_BOOT_VECTOR; // [RULE8]

  //////////////////////////////////////////////////////////////////////////////
  // Register decode
  //////////////////////////////////////////////////////////////////////////////

  logic [5:0] vmon_q;   // Voltage monitor control
  logic       lvd_q;    // Registered comparator for outputs
  logic       wr_vmon;  // Write to monitor control
  logic       wr_ctl0;  // Write to status control 0
  logic       wr_ctl1;  // Write to status control 1
  logic       lev_ok;   // Level field not reserved
  logic       src_pwr;  // Power-on or pin reset active
  logic       src_wdt;  // Watchdog reset active
  logic [7:0] rd_mux;   // Read data select

  assign wr_vmon = i_wr && (i_addr == `RSV_ADDR_VMON_CTRL);
  assign wr_ctl0 = i_wr && (i_addr == `RSV_ADDR_SYS_CTL0);
  assign wr_ctl1 = i_wr && (i_addr == `RSV_ADDR_SYS_CTL1);
  assign lev_ok  = i_wdata[`RSV_POR_LEV_HI:`RSV_POR_LEV_LO]
                   != `RSV_POR_LEV_RSVD; // [RULE13]
  assign src_pwr = lvl_any || (state_q == rsv_pkg::RSV_ST_HOLD);
  assign src_wdt = (state_q == rsv_pkg::RSV_ST_WDT);

  //////////////////////////////////////////////////////////////////////////////
  // Voltage monitor control
  //////////////////////////////////////////////////////////////////////////////

  // Cleared by power, pin or watchdog reset, not boot reset; reserved level code ignored
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vmon_q <= `RSV_VMON_RESET;
    end else if (reg_rst) begin
      vmon_q <= `RSV_VMON_RESET; // [RULE12]
    end else if (wr_vmon) begin
      vmon_q[`RSV_THROTTLE_BIT:0] <= i_wdata[`RSV_THROTTLE_BIT:0]; // [RULE15]
      if (lev_ok) begin
        vmon_q[`RSV_POR_LEV_HI:`RSV_POR_LEV_LO] <=
          i_wdata[`RSV_POR_LEV_HI:`RSV_POR_LEV_LO]; // [RULE13]
      end
    end
  end

  assign o_por_level = vmon_q[`RSV_POR_LEV_HI:`RSV_POR_LEV_LO];
  assign o_lvd_trip  = vmon_q[`RSV_TRIP_HI:`RSV_TRIP_LO]; // [RULE15]

  //////////////////////////////////////////////////////////////////////////////
  // Status bits
  //////////////////////////////////////////////////////////////////////////////

  // Hardware set wins over software clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      por_q    <= `RSV_POR_STAT_RESET;
      watchdog_status_bit_q   <= `RSV_WDT_STAT_RESET;
      memdis_q <= `RSV_MEMDIS_RESET;
    end else if (src_pwr) begin
      por_q    <= 1'b1; // [RULE6]
      watchdog_status_bit_q   <= 1'b0; // [RULE6]
      memdis_q <= 1'b0; // [RULE6]
    end else if (src_wdt) begin
      por_q  <= 1'b0; // [RULE6]
      watchdog_status_bit_q <= 1'b1; // [RULE6] [RULE20]
    end else begin
      if (wr_ctl0 && !i_wdata[`RSV_POR_STAT_BIT]) begin
        por_q <= 1'b0; // [RULE21]
      end
      if (wr_ctl0 && !i_wdata[`RSV_WDT_STAT_BIT]) begin
        watchdog_status_bit_q <= 1'b0; // [RULE20]
      end
      if (wr_ctl1) begin
        memdis_q <= i_wdata[`RSV_MEMDIS_BIT];
      end
    end
  end

  assign o_wdt_enable       = wdt_en; // [RULE21]
  assign o_mem_init_disable = memdis_q;

  //////////////////////////////////////////////////////////////////////////////
  // Comparator outputs
  //////////////////////////////////////////////////////////////////////////////

  // Registered copy of the comparator for outputs
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvd_q <= 1'b0;
    end else begin
      lvd_q <= lvd_s;
    end
  end

  assign o_throttle = vmon_q[`RSV_THROTTLE_BIT] && lvd_q; // [RULE14]
  assign o_lvd_irq  = lvd_q; // [RULE17]

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  //////////////////////////////////////////////////////////////////////////////

  // Read select; reserved bits and unmapped reads give zero
  always_comb begin
    rd_mux = `RSV_RDATA_ZERO;
    unique case (i_addr)
      `RSV_ADDR_VMON_CTRL: rd_mux[5:0] = vmon_q;
      `RSV_ADDR_VCMP_STAT: rd_mux[`RSV_VCMP_LVD_BIT] = lvd_s; // [RULE16]
      `RSV_ADDR_SYS_CTL0: begin
        rd_mux[`RSV_WDT_STAT_BIT] = watchdog_status_bit_q; // [RULE20]
        rd_mux[`RSV_POR_STAT_BIT] = por_q;
      end
      `RSV_ADDR_SYS_CTL1: rd_mux[`RSV_MEMDIS_BIT] = memdis_q;
      default: rd_mux = `RSV_RDATA_ZERO;
    endcase
  end

  // Read data in the cycle after the strobe only
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `RSV_RDATA_ZERO;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= `RSV_RDATA_ZERO;
    end
  end

endmodule // rsv_reset_seq

// ---- shared/rsv_params.svh ----
// Constants for the reset sequencer and voltage monitor
`ifndef RSV_PARAMS_SVH
`define RSV_PARAMS_SVH

// Clock and slow tick timing
`define RSV_CLK_PERIOD_NS   100
`define RSV_SLOW_PERIOD_US  30
`define RSV_SLOW_DIV        ((`RSV_SLOW_PERIOD_US * 1000) / `RSV_CLK_PERIOD_NS)
`define RSV_DIV_W           9

// Hold-off counts in slow ticks
`define RSV_CNT_W           12
`define RSV_TICKS_COARSE    12'h200
`define RSV_TICKS_PRECISE   12'h001
`define RSV_TICKS_EXT       12'h008
`define RSV_TICKS_WDT       12'h001
`define RSV_TICKS_BOOT_LP   12'h800
`define RSV_TICKS_BOOT_ON   12'h001
`define RSV_CNT_ONE         12'h001

// Boot time from release to first fetch
`define RSV_BOOT_TIME_US    2200
`define RSV_BOOT_CYCLES     ((`RSV_BOOT_TIME_US * 1000) / `RSV_CLK_PERIOD_NS)
`define RSV_BOOT_W          16
`define RSV_BOOT_VECTOR     16'h0000

// Register offsets
`define RSV_ADDR_VMON_CTRL  8'hE3
`define RSV_ADDR_VCMP_STAT  8'hE4
`define RSV_ADDR_SYS_CTL1   8'hFE
`define RSV_ADDR_SYS_CTL0   8'hFF

// Register reset values and field positions
`define RSV_VMON_RESET      6'h00
`define RSV_POR_LEV_HI      5
`define RSV_POR_LEV_LO      4
`define RSV_POR_LEV_RSVD    2'h3
`define RSV_THROTTLE_BIT    3
`define RSV_TRIP_HI         2
`define RSV_TRIP_LO         0
`define RSV_VCMP_LVD_BIT    1
`define RSV_WDT_STAT_BIT    5
`define RSV_POR_STAT_BIT    4
`define RSV_MEMDIS_BIT      0
`define RSV_POR_STAT_RESET  1'h1
`define RSV_WDT_STAT_RESET  1'h0
`define RSV_MEMDIS_RESET    1'h0
`define RSV_RDATA_ZERO      8'h00

`endif

// ---- shared/rsv_pkg.sv ----
// Types shared by the reset sequencer
package rsv_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    RSV_ST_RUN     = 3'h0,
    RSV_ST_HOLD    = 3'h1,
    RSV_ST_WDT     = 3'h2,
    RSV_ST_BOOT    = 3'h3,
    RSV_ST_BOOT_LP = 3'h4,
    RSV_ST_WAIT    = 3'h5
  } rsv_state_e;

  // Last reset source
  typedef enum logic [2:0] {
    RSV_SRC_COARSE  = 3'h0,
    RSV_SRC_PRECISE = 3'h1,
    RSV_SRC_EXT     = 3'h2,
    RSV_SRC_WDT     = 3'h3,
    RSV_SRC_BOOT    = 3'h4
  } rsv_src_e;

endpackage : rsv_pkg

// ---- verif/rsv_reset_seq_chk.sv ----
// Port-level property checker for the reset sequencer
`timescale 1ns/1ns
module rsv_reset_seq_chk (
  // Clock and reset
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  // Watched inputs
  input wire logic       i_coarse_por,
  input wire logic       i_ext_reset_pin,
  input wire logic       i_wdt_expire,
  input wire logic       i_lvd_cmp,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  // Watched outputs
  input wire logic       o_cpu_rst,
  input wire logic       o_reg_rst,
  input wire logic       o_trim_rst,
  input wire logic       o_main_osc_en,
  input wire logic       o_slow_osc_en,
  input wire logic       o_bandgap_en,
  input wire logic       o_code_start,
  input wire logic [1:0] o_por_level,
  input wire logic       o_throttle,
  input wire logic       o_lvd_irq,
  input wire logic       o_wdt_enable
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Run length of the main oscillator, saturating
  logic [15:0] osc_run_q;
  logic [15:0] osc_run_d;
  assign osc_run_d = !o_main_osc_en ? 16'h0000 :
                     (osc_run_q == 16'hFFFF) ? osc_run_q : osc_run_q + 16'h0001;
  // Counter register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_run_q <= 16'h0000;
    end else begin
      osc_run_q <= osc_run_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_BANDGAP: assert property (o_bandgap_en == 1'b1)
    else $error("bandgap enable dropped");
  AST_EXT_HOLD: assert property (i_ext_reset_pin [*4] |->
    o_cpu_rst && o_reg_rst && !o_main_osc_en) else $error("pin reset not held");
  AST_SLOW_OSC: assert property (i_coarse_por [*4] |-> !o_slow_osc_en)
    else $error("slow oscillator runs in coarse reset");
  AST_OSC_FIRST: assert property ($fell(o_cpu_rst) |-> osc_run_q >= 16'h012C)
    else $error("release without a full tick of oscillator");
  AST_TRIM: assert property (o_trim_rst |-> o_reg_rst)
    else $error("trim reset without register reset");
  AST_THROTTLE: assert property (o_throttle |-> o_lvd_irq)
    else $error("throttle without low voltage");
  AST_LVD_IRQ: assert property (i_lvd_cmp [*5] |-> o_lvd_irq)
    else $error("low voltage not signalled");
  AST_WDT_EN: assert property ($rose(o_wdt_enable) |-> $past(i_wr) &&
    $past(i_addr) == 8'hFF && ($past(i_wdata) & 8'h10) == 8'h00)
    else $error("watchdog enabled without clearing write");
  AST_WDT_DIS: assert property ($fell(o_wdt_enable) |-> $past(o_reg_rst))
    else $error("watchdog disabled outside reset");
  AST_WDT_OSC: assert property (i_wdt_expire && o_wdt_enable |=>
    o_main_osc_en [*8]) else $error("oscillator stopped in watchdog reset");
  AST_LEVEL: assert property (o_por_level != 2'h3)
    else $error("reserved level selected");
  AST_BOOT: assert property ($fell(o_cpu_rst) |-> !o_code_start [*8])
    else $error("code start too early");
endmodule // rsv_reset_seq_chk

bind rsv_reset_seq rsv_reset_seq_chk u_chk (.i_mclk, .i_rst_n, .i_coarse_por,
  .i_ext_reset_pin, .i_wdt_expire, .i_lvd_cmp, .i_addr, .i_wdata, .i_wr, .o_cpu_rst,
  .o_reg_rst, .o_trim_rst, .o_main_osc_en, .o_slow_osc_en, .o_bandgap_en, .o_code_start,
  .o_por_level, .o_throttle, .o_lvd_irq, .o_wdt_enable);

// ---- verif/testbench.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
module testbench;
  localparam int BOOT = 20;  // Short boot count
  localparam int TK   = 300; // Clocks per slow tick
  // Design inputs
  logic        i_mclk, i_rst_n, i_coarse_por, i_precise_por, i_ext_reset_pin;
  logic        i_wdt_expire, i_boot_reset_req, i_lvd_cmp, i_wr, i_rd;
  logic  [7:0] i_addr, i_wdata;
  // Design outputs
  logic  [7:0] o_rdata;
  logic        o_cpu_rst, o_reg_rst, o_trim_rst, o_main_osc_en, o_slow_osc_en;
  logic        o_bandgap_en, o_code_start, o_throttle, o_lvd_irq, o_wdt_enable;
  logic        o_mem_init_disable;
  logic [15:0] o_boot_vector;
  logic  [1:0] o_por_level;
  logic  [2:0] o_lvd_trip;
  // Model state and counters
  bit    [7:0] m_vmon, m_s0, m_s1, d;
  int          err_count, checks_done, cyc;

  rsv_reset_seq #(.BOOT_CYCLES(BOOT)) uut (.*);

  // Clock
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // Hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 250000) begin
      err_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks_done++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Register write, mirrored in the model
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    if (a == 8'hE3) m_vmon = {2'h0, (v[5:4] == 2'h3) ? m_vmon[5:4] : v[5:4], v[3:0]};
    if (a == 8'hFF) m_s0 = m_s0 & (v | 8'hCF);
    if (a == 8'hFE) m_s1 = v & 8'h01;
  endtask
  // Register read against an expected value
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, ex}, {8'h00, o_rdata});
  endtask
  // Model reaction to a reset
  task automatic mreset(input bit wdt);
    m_vmon = 8'h00;
    m_s0 = wdt ? 8'h20 : 8'h10;
    if (!wdt) m_s1 = 8'h00;
  endtask
  task automatic regs_chk();
    rd_chk(8'hE3, m_vmon);
    rd_chk(8'hFF, m_s0);
    rd_chk(8'hFE, m_s1);
    rd_chk(8'hE4, 8'h00);
    chk("wdt_en", {15'h0, ~m_s0[4]}, {15'h0, o_wdt_enable});
    chk("mem_dis", {15'h0, m_s1[0]}, {15'h0, o_mem_init_disable});
    chk("level", {14'h0, m_vmon[5:4]}, {14'h0, o_por_level});
    chk("trip", {13'h0, m_vmon[2:0]}, {13'h0, o_lvd_trip});
  endtask
  // Wait for release, then for the first fetch
  task automatic rel(input int n, input int lo);
    int c;
    c = 0;
    while (o_cpu_rst !== 1'b0 && c < 200000) begin
      @(posedge i_mclk);
      #1;
      c++;
    end
    chk("hold ok", 16'h1, {15'h0, c >= lo && c <= (n + 1) * TK + 10});
    c = 0;
    while (o_code_start !== 1'b1 && c < 100) begin
      @(posedge i_mclk);
      #1;
      c++;
    end
    chk("boot ok", 16'h1, {15'h0, c >= BOOT - 1 && c <= BOOT + 2});
    chk("vector", 16'h0000, o_boot_vector);
  endtask
  task automatic src(input int k, input logic v);
    if (k == 0) i_coarse_por <= v;
    if (k == 1) i_precise_por <= v;
    if (k == 2) i_ext_reset_pin <= v;
  endtask
  // One level-driven reset source, held then released
  task automatic episode(input int k, input int len, input int n);
    @(posedge i_mclk);
    src(k, 1'b1);
    repeat (len) @(posedge i_mclk);
    #1;
    chk("cpu_rst", 16'h1, {15'h0, o_cpu_rst});
    chk("main_osc", 16'h0, {15'h0, o_main_osc_en});
    chk("reg_rst", 16'h1, {15'h0, o_reg_rst});
    chk("trim_rst", {15'h0, k != 1}, {15'h0, o_trim_rst});
    chk("slow_osc", {15'h0, k != 0}, {15'h0, o_slow_osc_en});
    chk("bandgap", 16'h1, {15'h0, o_bandgap_en});
    @(posedge i_mclk);
    src(k, 1'b0);
    rel(n, n * TK);
    mreset(1'b0);
    regs_chk();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {i_coarse_por, i_precise_por, i_ext_reset_pin, i_wdt_expire} = 4'h0;
    {i_boot_reset_req, i_lvd_cmp, i_wr, i_rd} = 4'h0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_rst_n = 1'b0;
    void'($urandom(32'hE74D50AA));
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    episode(0, 20, 512);
    $display("test 1 coarse power-on done");
    repeat (4) begin
      d = $urandom & 8'h3F;
      wr(8'hE3, d);
      regs_chk();
    end
    wr(8'hE3, 8'h35);
    rd_chk(8'hE3, m_vmon);
    wr(8'hE4, 8'hFF);
    rd_chk(8'hE4, 8'h00);
    rd_chk(8'h10, 8'h00);
    $display("test 2 registers done");
    wr(8'hE3, 8'h1D);
    @(posedge i_mclk);
    i_lvd_cmp <= 1'b1;
    repeat (6) @(posedge i_mclk);
    #1;
    chk("throttle", 16'h1, {15'h0, o_throttle});
    chk("lvd_irq", 16'h1, {15'h0, o_lvd_irq});
    rd_chk(8'hE4, 8'h02);
    i_lvd_cmp <= 1'b0;
    repeat (6) @(posedge i_mclk);
    #1;
    chk("throttle", 16'h0, {15'h0, o_throttle});
    rd_chk(8'hE4, 8'h00);
    $display("test 3 low voltage done");
    wr(8'hFE, 8'h01);
    @(posedge i_mclk);
    i_boot_reset_req <= 1'b1;
    @(posedge i_mclk);
    i_boot_reset_req <= 1'b0;
    repeat (700) @(posedge i_mclk);
    #1;
    chk("boot hold", 16'h1, {15'h0, o_cpu_rst});
    chk("boot osc", 16'h0, {15'h0, o_main_osc_en});
    regs_chk();
    episode(2, 6 + ($urandom % 30), 8);
    $display("test 4 boot abort and pin reset done");
    wr(8'hE3, 8'h12);
    episode(1, 10, 1);
    $display("test 5 precise power-on done");
    wr(8'hFF, 8'h00);
    wr(8'hFE, 8'h01);
    wr(8'hE3, 8'h2A);
    regs_chk();
    @(posedge i_mclk);
    i_wdt_expire <= 1'b1;
    @(posedge i_mclk);
    i_wdt_expire <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("wdt rst", 16'h1, {15'h0, o_cpu_rst});
    chk("wdt osc", 16'h1, {15'h0, o_main_osc_en});
    rel(1, TK - 5);
    mreset(1'b1);
    regs_chk();
    wr(8'hFF, 8'hFF);
    rd_chk(8'hFF, m_s0);
    wr(8'hFF, 8'h10);
    regs_chk();
    $display("test 6 watchdog done");
    tally_and_finish();
  end
endmodule // testbench
